// >>> rtl/coa_core.sv
/*
 * coa_core: instruction fetch, addressing mode decode, effective address
 * forming, branch resolution and register/memory execution of an 8-bit core.
 * Assumes a memory whose read data answers combinationally to the address
 * held on mem_req during the cycle that mem_req.rd is high.
 */
// Functional notes
// - The core decodes a 62-instruction set family using eight addressing modes.
// - Unsigned multiply puts the high product byte in the index and the low in the accumulator.
// - Inherent instructions are one byte long and form no operand address.
// - Inherent instructions may act on core registers alone, e.g. setting carry or incrementing.
// - Immediate instructions are two bytes and use the second byte directly as data.
// - Direct instructions are two bytes with the high address byte forced to zero.
// - Extended instructions are three bytes giving the address high byte then low byte.
// - Indexed without offset is one byte with address zero high byte and index low byte.
// - Indexed with 8-bit offset is two bytes, address is the unsigned index plus offset.
// - Indexed with 16-bit offset is three bytes, index added to a high-then-low offset.
// - Relative addressing serves branches only, taken branches add the signed offset.
// - The branch offset is two's complement, reaching -128 to +127 from the next instruction.
// - Register/memory instructions pair the accumulator or index with a memory operand.
// - The register/memory group holds adds, and, bit test, compares, xor, loads, stores, or, subtracts.
`timescale 1ns/1ps
module coa_core
    import coa_pkg::*;
(
    // clock and reset
    input  wire logic         clock,
    input  wire logic         reset_n,
    // memory bus
    output coa_mem_req_t      mem_req,
    input  wire logic [7:0]   mem_rdata,
    // core state
    output logic [7:0]        acc,
    output logic [7:0]        index,
    output logic [15:0]       pc,
    output coa_flags_t        flags,
    // status
    output logic              illegal_opcode,
    output logic              instr_done
);

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic is_store(input logic [3:0] op);
        return (op == OP_WRITE_ACC) || (op == OP_WRITE_IDX);
    endfunction

    // operand access: store writes the register, others read memory
    function automatic coa_mem_req_t access(input logic [15:0] ea, input logic [3:0] op,
                                            input logic [7:0] a, input logic [7:0] x);
        coa_mem_req_t r;
        r.rd    = !is_store(op);
        r.wr    = is_store(op);
        r.addr  = ea;
        r.wdata = (op == OP_WRITE_ACC) ? a : ((op == OP_WRITE_IDX) ? x : 8'h00);
        return r;
    endfunction

    function automatic coa_alu_t alu_op(input logic [3:0] op, input logic [7:0] a,
                                        input logic [7:0] x, input logic [7:0] m,
                                        input coa_flags_t f);
        coa_alu_t   r;
        logic [8:0] s;
        logic       arith;
        s     = {1'b0, a};
        arith = 1'b0;
        case (op)
            OP_ADD: begin
                s     = {1'b0, a} + {1'b0, m};
                arith = 1'b1;
            end
            OP_ADC: begin
                s     = {1'b0, a} + {1'b0, m} + {8'h00, f.c};
                arith = 1'b1;
            end
            OP_SUB, OP_CMP: begin
                s     = {1'b0, a} - {1'b0, m};
                arith = 1'b1;
            end
            OP_MINUS_BORROW: begin
                s     = {1'b0, a} - {1'b0, m} - {8'h00, f.c};
                arith = 1'b1;
            end
            OP_CPX: begin
                s     = {1'b0, x} - {1'b0, m};
                arith = 1'b1;
            end
            OP_AND, OP_BIT: s = {1'b0, a & m};
            OP_XOR_ACC: s = {1'b0, a ^ m};
            OP_OR_ACC: s = {1'b0, a | m};
            OP_LOAD_ACC, OP_LOAD_IDX: s = {1'b0, m};
            OP_WRITE_IDX: s = {1'b0, x};
            default: s = {1'b0, a};
        endcase
        r.res     = s[7:0];
        r.flags.n = s[7];
        r.flags.z = (s[7:0] == 8'h00);
        r.flags.c = arith ? s[8] : f.c;
        r.wr_acc  = (op == OP_ADD) || (op == OP_ADC) || (op == OP_SUB) ||
                    (op == OP_MINUS_BORROW) || (op == OP_AND) || (op == OP_XOR_ACC) ||
                    (op == OP_OR_ACC) || (op == OP_LOAD_ACC);
        r.wr_idx  = (op == OP_LOAD_IDX);
        return r;
    endfunction

    // ************************************************************
    // registers and next values
    // ************************************************************
    coa_state_t   state;
    coa_state_t   next_state;
    logic [3:0]   mode_q;
    logic [3:0]   next_mode;
    logic [3:0]   op_q;
    logic [3:0]   next_op;
    logic [7:0]   b1;
    logic [7:0]   next_b1;
    logic [15:0]  next_pc;
    logic [7:0]   next_acc;
    logic [7:0]   next_index;
    coa_flags_t   next_flags;
    coa_mem_req_t next_mem;
    logic         next_illegal;
    logic         next_done;

    // ************************************************************
    // decode and address forming
    // ************************************************************
    wire logic [3:0]  in_mode = mem_rdata[COA_MODE_MSB:COA_MODE_LSB];
    wire logic [3:0]  in_op   = mem_rdata[COA_OP_MSB:0];

    // only the eight modes and their operation ranges are legal
    wire logic        in_legal =
        (in_mode == MODE_INH) ? (in_op <= INH_PRODUCT) :
        (in_mode == MODE_REL) ? (in_op <= BR_MI) :
        (in_mode == MODE_IMM) ? (in_op <= OP_LOAD_IDX) :
        (in_mode <= MODE_IX2) ? (in_op <= OP_WRITE_IDX) : 1'b0;

    wire logic        branch_taken =
        (op_q == BR_ALWAYS) ? 1'b1 : (op_q == BR_NEVER) ? 1'b0 :
        (op_q == BR_CC) ? !flags.c : (op_q == BR_CS) ? flags.c :
        (op_q == BR_NE) ? !flags.z : (op_q == BR_EQ) ? flags.z :
        (op_q == BR_PL) ? !flags.n : flags.n;

    // sign-extended offset from the address after the branch
    wire logic [15:0] rel_target = pc + {{8{mem_rdata[7]}}, mem_rdata};
    wire logic [15:0] dir_ea     = {COA_PAGE0_HIGH, mem_rdata};
    // index as low byte on page zero
    wire logic [15:0] ix_ea      = {COA_PAGE0_HIGH, index};
    // unsigned 9-bit sum reaches at most 16'h01FE
    wire logic [8:0]  ix1_sum    = {1'b0, index} + {1'b0, mem_rdata};
    wire logic [15:0] ix1_ea     = {7'h00, ix1_sum};
    wire logic [15:0] ext_ea     = {b1, mem_rdata};
    // index plus 16-bit offset, carry out dropped on purpose
    wire logic [15:0] ix2_ea     = ext_ea + {8'h00, index};
    wire logic [15:0] product    = {8'h00, acc} * {8'h00, index};
    wire coa_alu_t    alu_r      = alu_op(op_q, acc, index, mem_rdata, flags);
    wire logic [7:0]  inc_acc    = acc + 8'h01;

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        next_state   = state;
        next_pc      = pc;
        next_acc     = acc;
        next_index   = index;
        next_flags   = flags;
        next_mode    = mode_q;
        next_op      = op_q;
        next_b1      = b1;
        next_mem     = mem_req;
        next_mem.rd  = 1'b0;
        next_mem.wr  = 1'b0;
        next_illegal = 1'b0;
        next_done    = 1'b0;
        case (state)
            ST_FETCH: begin
                next_mem.rd   = 1'b1;
                next_mem.addr = pc;
                next_pc       = pc + 16'h0001;
                next_state    = ST_OPCODE;
            end
            ST_OPCODE: begin
                next_mode = in_mode;
                next_op   = in_op;
                if (!in_legal) begin
                    // unknown opcodes retire as one-byte no-ops so fetch never stalls
                    next_illegal = 1'b1;
                    next_done    = 1'b1;
                    next_state   = ST_FETCH;
                end else if (in_mode == MODE_INH) begin
                    // one byte, registers only, no operand fetch
                    next_done  = 1'b1;
                    next_state = ST_FETCH;
                    case (in_op)
                        INH_SET_CARRY: next_flags.c = 1'b1;
                        INH_CLR_CARRY: next_flags.c = 1'b0;
                        INH_INC_ACC: begin
                            next_acc     = inc_acc;
                            next_flags.n = inc_acc[7];
                            next_flags.z = (inc_acc == 8'h00);
                        end
                        INH_PRODUCT: begin
                            // high byte to index, low byte to accumulator
                            next_index   = product[15:8];
                            next_acc     = product[7:0];
                            next_flags.c = 1'b0;
                        end
                        default: next_done = 1'b1;
                    endcase
                end else if (in_mode == MODE_IX) begin
                    // operand access straight after the opcode
                    next_mem   = access(ix_ea, in_op, acc, index);
                    next_state = is_store(in_op) ? ST_WRITE : ST_EXEC;
                end else begin
                    next_mem.rd   = 1'b1;
                    next_mem.addr = pc;
                    next_pc       = pc + 16'h0001;
                    next_state    = ST_BYTE1;
                end
            end
            ST_BYTE1: begin
                next_b1 = mem_rdata;
                case (mode_q)
                    MODE_REL: begin
                        // taken branch adds offset, else fall through
                        if (branch_taken) begin
                            next_pc = rel_target;
                        end
                        next_done  = 1'b1;
                        next_state = ST_FETCH;
                    end
                    MODE_IMM: begin
                        // literal byte used directly, no address formed
                        next_acc   = alu_r.wr_acc ? alu_r.res : acc;
                        next_index = alu_r.wr_idx ? alu_r.res : index;
                        next_flags = alu_r.flags;
                        next_done  = 1'b1;
                        next_state = ST_FETCH;
                    end
                    MODE_DIR: begin
                        next_mem   = access(dir_ea, op_q, acc, index);
                        next_state = is_store(op_q) ? ST_WRITE : ST_EXEC;
                    end
                    MODE_IX1: begin
                        next_mem   = access(ix1_ea, op_q, acc, index);
                        next_state = is_store(op_q) ? ST_WRITE : ST_EXEC;
                    end
                    default: begin
                        next_mem.rd   = 1'b1;
                        next_mem.addr = pc;
                        next_pc       = pc + 16'h0001;
                        next_state    = ST_BYTE2;
                    end
                endcase
            end
            ST_BYTE2: begin
                next_mem   = access((mode_q == MODE_EXT) ? ext_ea : ix2_ea, op_q, acc, index);
                next_state = is_store(op_q) ? ST_WRITE : ST_EXEC;
            end
            ST_EXEC: begin
                // memory byte meets accumulator or index
                next_acc   = alu_r.wr_acc ? alu_r.res : acc;
                next_index = alu_r.wr_idx ? alu_r.res : index;
                next_flags = alu_r.flags;
                next_done  = 1'b1;
                next_state = ST_FETCH;
            end
            ST_WRITE: begin
                // stores leave n and z describing the stored byte
                next_flags = alu_r.flags;
                next_done  = 1'b1;
                next_state = ST_FETCH;
            end
            default: next_state = ST_FETCH;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state          <= ST_FETCH;
            pc             <= COA_PC_RESET;
            acc            <= 8'h00;
            index          <= 8'h00;
            flags          <= '0;
            mode_q         <= MODE_INH;
            op_q           <= INH_NOP;
            b1             <= 8'h00;
            mem_req        <= '0;
            illegal_opcode <= 1'b0;
            instr_done     <= 1'b0;
        end else begin
            state          <= next_state;
            pc             <= next_pc;
            acc            <= next_acc;
            index          <= next_index;
            flags          <= next_flags;
            mode_q         <= next_mode;
            op_q           <= next_op;
            b1             <= next_b1;
            mem_req        <= next_mem;
            illegal_opcode <= next_illegal;
            instr_done     <= next_done;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    product_split_a: assert property (
        (state == ST_OPCODE && in_mode == MODE_INH && in_op == INH_PRODUCT)
        |=> ({index, acc} == $past(acc) * $past(index)))
        else $error("product not split into index and accumulator");

    inherent_len_a: assert property (
        (state == ST_OPCODE && in_mode == MODE_INH && in_legal)
        |=> (state == ST_FETCH && pc == $past(pc) && !mem_req.rd && !mem_req.wr))
        else $error("inherent instruction fetched more bytes");

    immediate_len_a: assert property (
        (state == ST_OPCODE && in_mode == MODE_IMM && in_legal)
        |-> ##2 (state == ST_FETCH && pc == $past(pc, 2) + 16'h0001 && !mem_req.wr))
        else $error("immediate instruction not two bytes");

    direct_page_a: assert property (
        ((state == ST_EXEC || state == ST_WRITE) && mode_q == MODE_DIR)
        |-> (mem_req.addr[15:8] == COA_PAGE0_HIGH))
        else $error("direct operand left page zero");

    ext_address_a: assert property (
        (state == ST_BYTE2 && mode_q == MODE_EXT)
        |=> (mem_req.addr == {$past(b1), $past(mem_rdata)}))
        else $error("extended address bytes misordered");

    ix_page_a: assert property (
        (state == ST_OPCODE && in_mode == MODE_IX && in_legal)
        |=> (mem_req.addr == {COA_PAGE0_HIGH, $past(index)} && (mem_req.rd ^ mem_req.wr)))
        else $error("indexed operand address wrong");

    ix1_reach_a: assert property (
        ((state == ST_EXEC || state == ST_WRITE) && mode_q == MODE_IX1)
        |-> (mem_req.addr <= COA_IX1_LAST))
        else $error("8-bit offset address beyond reach");

    branch_target_a: assert property (
        (state == ST_BYTE1 && mode_q == MODE_REL)
        |=> (pc == (branch_taken ? $past(pc) + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)}
                                  : $past(pc))))
        else $error("branch target wrong");

    store_data_a: assert property (
        mem_req.wr |-> (mem_req.wdata == ((op_q == OP_WRITE_ACC) ? acc : index)) ##1 !mem_req.wr)
        else $error("stored byte is not the register");

endmodule // coa_core

// >>> rtl/coa_pkg.sv
/*
 * coa_pkg: shared constants and types of the operand addressing core.
 * Assumes a 16-bit address space and an 8-bit memory bus on one clock.
 */
package coa_pkg;

    // ************************************************************
    // instruction set shape
    // ************************************************************
    localparam int COA_NUM_INSTRUCTIONS = 62;
    localparam int COA_NUM_MODES        = 8;

    // ************************************************************
    // opcode layout: upper nibble mode, lower nibble operation
    // ************************************************************
    localparam int COA_MODE_MSB = 7;
    localparam int COA_MODE_LSB = 4;
    localparam int COA_OP_MSB   = 3;

    localparam logic [3:0] MODE_INH = 4'h0;
    localparam logic [3:0] MODE_REL = 4'h1;
    localparam logic [3:0] MODE_IMM = 4'h2;
    localparam logic [3:0] MODE_DIR = 4'h3;
    localparam logic [3:0] MODE_EXT = 4'h4;
    localparam logic [3:0] MODE_IX  = 4'h5;
    localparam logic [3:0] MODE_IX1 = 4'h6;
    localparam logic [3:0] MODE_IX2 = 4'h7;

    // register/memory operations
    localparam logic [3:0] OP_ADD          = 4'h0;
    localparam logic [3:0] OP_ADC          = 4'h1;
    localparam logic [3:0] OP_SUB          = 4'h2;
    localparam logic [3:0] OP_MINUS_BORROW = 4'h3;
    localparam logic [3:0] OP_AND          = 4'h4;
    localparam logic [3:0] OP_BIT          = 4'h5;
    localparam logic [3:0] OP_CMP          = 4'h6;
    localparam logic [3:0] OP_CPX          = 4'h7;
    localparam logic [3:0] OP_XOR_ACC      = 4'h8;
    localparam logic [3:0] OP_OR_ACC       = 4'h9;
    localparam logic [3:0] OP_LOAD_ACC     = 4'hA;
    localparam logic [3:0] OP_LOAD_IDX     = 4'hB;
    localparam logic [3:0] OP_WRITE_ACC    = 4'hC;
    localparam logic [3:0] OP_WRITE_IDX    = 4'hD;

    // inherent operations
    localparam logic [3:0] INH_NOP       = 4'h0;
    localparam logic [3:0] INH_SET_CARRY = 4'h1;
    localparam logic [3:0] INH_CLR_CARRY = 4'h2;
    localparam logic [3:0] INH_INC_ACC   = 4'h3;
    localparam logic [3:0] INH_PRODUCT   = 4'h4;

    // branch conditions
    localparam logic [3:0] BR_ALWAYS = 4'h0;
    localparam logic [3:0] BR_NEVER  = 4'h1;
    localparam logic [3:0] BR_CC     = 4'h2;
    localparam logic [3:0] BR_CS     = 4'h3;
    localparam logic [3:0] BR_NE     = 4'h4;
    localparam logic [3:0] BR_EQ     = 4'h5;
    localparam logic [3:0] BR_PL     = 4'h6;
    localparam logic [3:0] BR_MI     = 4'h7;

    // ************************************************************
    // reset values and fixed address parts
    // ************************************************************
    localparam logic [15:0] COA_PC_RESET   = 16'h0000;
    localparam logic [7:0]  COA_PAGE0_HIGH = 8'h00;
    localparam logic [15:0] COA_IX1_LAST   = 16'h01FE;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_FETCH  = 3'h0,
        ST_OPCODE = 3'h1,
        ST_BYTE1  = 3'h3,
        ST_BYTE2  = 3'h2,
        ST_EXEC   = 3'h6,
        ST_WRITE  = 3'h7
    } coa_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } coa_mem_req_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
    } coa_flags_t;

    typedef struct packed {
        logic [7:0] res;
        coa_flags_t flags;
        logic       wr_acc;
        logic       wr_idx;
    } coa_alu_t;

endpackage

// >>> testbench/coa_mem_model.sv
/*
 * coa_mem_model: behavioural program and data memory for the core.
 * Assumes one clock; read data answers combinationally while rd is high.
 */
`timescale 1ns/1ps
module coa_mem_model
    import coa_pkg::*;
(
    // clock
    input  wire logic         clock,
    // memory bus
    input  wire coa_mem_req_t mem_req,
    output logic [7:0]        mem_rdata
);
    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0] mem [65536];
    logic [7:0] last = 8'h00;

    initial for (int i = 0; i < 65536; i++) mem[i] = 8'h00;

    // an idle bus shows the inverse of the last byte, so stale data never matches
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last;

    always @(posedge clock) begin
        if (mem_req.rd) last <= mem[mem_req.addr];
        if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
    end

    task automatic poke(input logic [15:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask

    function automatic logic [7:0] peek(input logic [15:0] a);
        return mem[a];
    endfunction
endmodule // coa_mem_model

// >>> testbench/cpu_operand_addressing_tb_top.sv
/*
 * cpu_operand_addressing_tb_top: directed bench for the addressing core.
 * Assumes the memory model beside it; the program is laid down just ahead of the core.
 */
`timescale 1ns/1ps
module cpu_operand_addressing_tb_top;
    import coa_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic         clock = 1'b0;
    logic         reset_n = 1'b0;
    coa_mem_req_t mem_req;
    logic [7:0]   mem_rdata;
    logic [7:0]   acc;
    logic [7:0]   index;
    logic [15:0]  pc;
    coa_flags_t   flags;
    logic         illegal_opcode;
    logic         instr_done;
    int           fail_count = 0;
    int           compares = 0;
    int           cycles = 0;
    logic [15:0]  ptr = 16'h0000;

    coa_core coa_core_inst (.clock(clock), .reset_n(reset_n), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .acc(acc), .index(index), .pc(pc), .flags(flags),
        .illegal_opcode(illegal_opcode), .instr_done(instr_done));
    coa_mem_model coa_mem_model_inst (.clock(clock), .mem_req(mem_req),
        .mem_rdata(mem_rdata));

    initial forever #25 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            fail_count++;
            $display("unexpected at %0t: run did not finish", $time);
            tally_and_finish();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic put(input logic [7:0] b);
        coa_mem_model_inst.poke(ptr, b);
        ptr = ptr + 16'h0001;
    endtask

    // lays one instruction at the expected pc, waits for retire, checks the next pc
    task automatic step(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                        input int n, input logic taken);
        put(op);
        if (n > 1) put(b1);
        if (n > 2) put(b2);
        if (taken) ptr = ptr + {{8{b1[7]}}, b1};
        @(negedge clock);
        for (int i = 0; i < 12 && instr_done !== 1'b1; i++) @(negedge clock);
        check_val({15'h0000, instr_done}, 16'h0001, "retire");
        check_val(pc, ptr, "next pc");
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic s_inherent;
        step(8'h01, 8'h00, 8'h00, 1, 1'b0);
        check_val({15'h0000, flags.c}, 16'h0001, "carry set");
        step(8'h02, 8'h00, 8'h00, 1, 1'b0);
        check_val({15'h0000, flags.c}, 16'h0000, "carry clear");
        step(8'h03, 8'h00, 8'h00, 1, 1'b0);
        check_val({8'h00, acc}, 16'h0001, "increment");
    endtask

    task automatic s_product;
        step(8'h2A, 8'hC5, 8'h00, 2, 1'b0);
        step(8'h2B, 8'h3B, 8'h00, 2, 1'b0);
        check_val({index, acc}, 16'h3BC5, "immediate loads");
        step(8'h04, 8'h00, 8'h00, 1, 1'b0);
        check_val({index, acc}, 16'h2D67, "product");
    endtask

    task automatic s_modes;
        coa_mem_model_inst.poke(16'h0044, 8'h5A);
        coa_mem_model_inst.poke(16'h0144, 8'hA5);
        coa_mem_model_inst.poke(16'h9A3C, 8'h77);
        coa_mem_model_inst.poke(16'h01FE, 8'h3E);
        coa_mem_model_inst.poke(16'h00EF, 8'h6B);
        step(8'h3A, 8'h44, 8'h00, 2, 1'b0);
        check_val({8'h00, acc}, 16'h005A, "direct");
        step(8'h4A, 8'h9A, 8'h3C, 3, 1'b0);
        check_val({8'h00, acc}, 16'h0077, "extended");
        step(8'h2B, 8'h44, 8'h00, 2, 1'b0);
        step(8'h5A, 8'h00, 8'h00, 1, 1'b0);
        check_val({8'h00, acc}, 16'h005A, "indexed plain");
        step(8'h2B, 8'hFF, 8'h00, 2, 1'b0);
        step(8'h6A, 8'hFF, 8'h00, 2, 1'b0);
        check_val({8'h00, acc}, 16'h003E, "indexed 8-bit top");
        step(8'h7A, 8'hFF, 8'hF0, 3, 1'b0);
        check_val({8'h00, acc}, 16'h006B, "indexed 16-bit wrap");
    endtask

    task automatic s_store;
        step(8'h2A, 8'h91, 8'h00, 2, 1'b0);
        step(8'h3C, 8'h50, 8'h00, 2, 1'b0);
        check_val({8'h00, coa_mem_model_inst.peek(16'h0050)}, 16'h0091, "store");
        step(8'h3D, 8'h51, 8'h00, 2, 1'b0);
        check_val({8'h00, coa_mem_model_inst.peek(16'h0051)}, 16'h00FF, "store index");
    endtask

    task automatic s_alu;
        logic [3:0] ops [11];
        logic [7:0] res [11];
        ops = '{OP_ADD, OP_ADC, OP_SUB, OP_MINUS_BORROW, OP_AND, OP_BIT, OP_CPX, OP_XOR_ACC,
                OP_OR_ACC, OP_LOAD_ACC, OP_CMP};
        res = '{8'hD1, 8'hD2, 8'h67, 8'h66, 8'h14, 8'h9C, 8'h9C, 8'hA9, 8'hBD, 8'h35, 8'h9C};
        // carry is set before each operation so carry-in and borrow-in are seen
        for (int i = 0; i < 11; i++) begin
            step(8'h2A, 8'h9C, 8'h00, 2, 1'b0);
            step(8'h01, 8'h00, 8'h00, 1, 1'b0);
            step({MODE_IMM, ops[i]}, 8'h35, 8'h00, 2, 1'b0);
            check_val({8'h00, acc}, {8'h00, res[i]}, "operation");
        end
        check_val({13'h0, flags}, 16'h0000, "compare flags");
    endtask

    task automatic s_branch;
        step(8'h11, 8'h05, 8'h00, 2, 1'b0);
        step(8'h12, 8'h02, 8'h00, 2, 1'b1);
        step(8'h13, 8'h40, 8'h00, 2, 1'b0);
        step(8'h10, 8'h80, 8'h00, 2, 1'b1);
        step(8'h10, 8'h7F, 8'h00, 2, 1'b1);
        step(8'h80, 8'h00, 8'h00, 1, 1'b0);
        check_val({15'h0000, illegal_opcode}, 16'h0001, "undecoded");
    endtask

    // ************************************************************
    // sequence and verdict
    // ************************************************************
    task automatic tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        s_inherent();
        s_product();
        s_modes();
        s_store();
        s_alu();
        s_branch();
        tally_and_finish();
    end
endmodule // cpu_operand_addressing_tb_top
